// file: apr_mem_model.sv
// Data memory model that answers the unit's word reads after a set latency.
// Assumes the testbench loads mem and drives lat and fault_addr.
`timescale 1ns/1ps
module table_mem_model (
	input  wire logic                mclk,
	input  wire logic                srst,
	input  wire feval_pkg::mem_req_t req,
	input  wire logic [3:0]          lat,
	input  wire logic [15:0]         fault_addr,
	output logic [15:0]              rdata,
	output logic                     ack,
	output logic                     fault
);
	import feval_pkg::*;
	logic [15:0] mem [0:255];
	logic [3:0]  wait_cnt;
	// One ack per read; between acks the data toggles so stale words are never trusted
	always_ff @(posedge mclk) begin
		ack <= 1'b0;
		fault <= 1'b0;
		rdata <= srst ? 16'h0000 : ~rdata;
		wait_cnt <= 4'h0;
		if (!srst && req.rd && !ack) begin
			if (wait_cnt >= lat) begin
				ack <= 1'b1;
				fault <= req.addr == fault_addr;
				rdata <= mem[req.addr[7:0]];
			end else begin
				wait_cnt <= wait_cnt + 4'h1;
			end
		end
	end
endmodule

// file: apr_pkg.sv
// Package for the function evaluation unit: register map, header fields,
// sine table, carrier structs and sequencer states.
// Assumes a 32-bit APB master and a data memory on mclk that acks each read after a latency.
package feval_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_OPER     = 8'h04;
	localparam logic [7:0] OFS_SRC      = 8'h08;
	localparam logic [7:0] OFS_GO       = 8'h0c;
	localparam logic [7:0] OFS_RESULT   = 8'h10;
	localparam logic [7:0] OFS_FLAGS    = 8'h14;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;

	localparam int CTRL_EXEC  = 0;
	localparam int CTRL_CONST = 1;
	localparam int IRQ_DONE   = 0;
	localparam int IRQ_ERR    = 1;

	localparam logic [15:0] RST_WORD = 16'h0000;

	// ----------------------------------------------------------------
	// Operand encodings and limits
	// ----------------------------------------------------------------
	localparam logic [15:0] SEL_SINE   = 16'h0000;
	localparam logic [15:0] SEL_COS    = 16'h0001;
	localparam logic [15:0] ANGLE_MAX  = 16'h0384;
	localparam logic [15:0] FRAC_MAX   = 16'h270f;
	localparam int          HDR_OUT_BIN = 14;
	localparam int          HDR_IN_BIN  = 15;
	localparam int          HDR_MIRROR  = 13;

	// Sine of whole degrees 0..90, scaled by 10000, truncated
	localparam logic [13:0] SINE_TAB [0:90] = '{
		0, 174, 348, 523, 697, 871, 1045, 1218, 1391, 1564, 1736, 1908, 2079,
		2249, 2419, 2588, 2756, 2923, 3090, 3255, 3420, 3583, 3746, 3907, 4067,
		4226, 4383, 4539, 4694, 4848, 5000, 5150, 5299, 5446, 5591, 5735, 5877,
		6018, 6156, 6293, 6427, 6560, 6691, 6819, 6946, 7071, 7193, 7313, 7431,
		7547, 7660, 7771, 7880, 7986, 8090, 8191, 8290, 8386, 8480, 8571, 8660,
		8746, 8829, 8910, 8987, 9063, 9135, 9205, 9271, 9335, 9396, 9455, 9510,
		9563, 9612, 9659, 9702, 9743, 9781, 9816, 9848, 9876, 9902, 9925, 9945,
		9961, 9975, 9986, 9993, 9998, 10000};

	// ----------------------------------------------------------------
	// Carriers and states
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        rd;
		logic [15:0] addr;
	} mem_req_t;

	typedef struct packed {
		logic top;
		logic zero;
		logic err;
	} flags_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_HDR  = 3'b001,
		ST_XMAX = 3'b011,
		ST_Y0   = 3'b010,
		ST_XK   = 3'b110,
		ST_YK   = 3'b111
	} state_t;

endpackage

// file: trig_and_piecewise_linear_evaluator.sv
// Function evaluation unit: sine/cosine of a BCD angle, or a table-driven
// piecewise-linear function read from data memory, with result flags.
// Assumes an APB master on mclk and a data memory that answers reads with
// mem_ack (and mem_fault for a missing word) on the same clock.
//
// Contract
// - No computation and no result or flag change unless execution condition set
// - Constant operand 0000 selects sine, 0001 selects cosine
// - Trig result is four BCD fraction digits, lower digits truncated
// - Full-scale trig result saturates at 9999
// - Address operand selects a piecewise-linear table at that address
// - Source read as BCD or binary per header input form
// - Header low byte is segment count minus one
// - Header bit 14 output form, bit 15 input form, one means binary
// - Table read contiguously: Xmax, Y0, then Xk/Yk pairs
// - First endpoint X is implicitly zero
// - Header bit 13 mirrors the graph left to right
// - Error when a trig angle exceeds 0900
// - Error on a constant operand other than the two selectors
// - Error on unreadable table or missing or non-BCD data word
// - Zero flag set when written value is 0000
// - Top-bit flag follows bit 15 of written value
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps

module trig_and_piecewise_linear_evaluator #(
	parameter int MAX_SEGMENTS = 256
) (
	input  wire logic               mclk,
	input  wire logic               srst,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	output feval_pkg::mem_req_t     mem_req,
	input  wire logic [15:0]        mem_rdata,
	input  wire logic               mem_ack,
	input  wire logic               mem_fault,
	output feval_pkg::flags_t       flags,
	output logic                    irq
);
	import feval_pkg::*;

	if (MAX_SEGMENTS < 1 || MAX_SEGMENTS > 256) begin : g_chk
		$error("MAX_SEGMENTS must be 1..256");
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic bcd_ok(input logic [15:0] v);
		return (v[15:12] < 4'ha) && (v[11:8] < 4'ha) &&
			(v[7:4] < 4'ha) && (v[3:0] < 4'ha);
	endfunction

	function automatic logic [15:0] bcd2bin(input logic [15:0] v);
		int s;
		s = v[15:12] * 1000 + v[11:8] * 100 + v[7:4] * 10 + v[3:0];
		return 16'(s);
	endfunction

	function automatic logic [15:0] bin2bcd(input logic [15:0] v);
		return {4'(v / 16'd1000), 4'((v / 16'd100) % 16'd10),
			4'((v / 16'd10) % 16'd10), 4'(v % 16'd10)};
	endfunction

	// Tenths of a degree to a 0..9999 binary fraction
	function automatic logic [15:0] sine_of(input logic [15:0] tenths);
		int idx;
		int fr;
		int s;
		idx = tenths / 10;
		fr  = tenths % 10;
		if (idx >= 90)
			s = SINE_TAB[90];
		else
			s = SINE_TAB[idx] + ((SINE_TAB[idx + 1] - SINE_TAB[idx]) * fr) / 10;
		if (s > FRAC_MAX)
			s = FRAC_MAX;
		return 16'(s);
	endfunction

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	logic        exec_cond;
	logic        oper_const;
	logic [15:0] oper;
	logic [15:0] src;
	logic [15:0] result;
	logic [1:0]  irq_stat;
	logic [1:0]  irq_mask;
	state_t      state;
	logic        fin_valid;
	logic        fin_err;
	logic [15:0] fin_val;
	logic        access;
	logic        wr_en;
	logic        hit;
	logic        go_start;

	assign access   = psel & penable & ~pready;
	assign wr_en    = psel & penable & pready & pwrite & ~pslverr;
	assign hit      = (paddr[1:0] == 2'b00) && (paddr <= OFS_IRQ_MASK);
	assign go_start = wr_en && (paddr == OFS_GO) && (state == ST_IDLE) && !fin_valid;

	always_ff @(posedge mclk) begin
		if (srst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= access;
			pslverr <= access & ~hit;
			if (access) begin
				case (paddr)
					OFS_CTRL:     prdata <= {30'h0, oper_const, exec_cond};
					OFS_OPER:     prdata <= {16'h0, oper};
					OFS_SRC:      prdata <= {16'h0, src};
					OFS_GO:       prdata <= {31'h0, state != ST_IDLE};
					OFS_RESULT:   prdata <= {16'h0, result};
					OFS_FLAGS:    prdata <= {29'h0, flags};
					OFS_IRQ_STAT: prdata <= {30'h0, irq_stat};
					OFS_IRQ_MASK: prdata <= {30'h0, irq_mask};
					default:      prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			exec_cond  <= 1'b0;
			oper_const <= 1'b0;
			oper       <= RST_WORD;
			src        <= RST_WORD;
			irq_mask   <= 2'b00;
		end else if (wr_en) begin
			case (paddr)
				OFS_CTRL: begin
					exec_cond  <= pwdata[CTRL_EXEC];
					oper_const <= pwdata[CTRL_CONST];
				end
				OFS_OPER:     oper <= pwdata[15:0];
				OFS_SRC:      src <= pwdata[15:0];
				OFS_IRQ_MASK: irq_mask <= pwdata[1:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	logic [1:0] irq_set;
	logic [1:0] irq_clr;

	assign irq_set = fin_valid ? {fin_err, 1'b1} : 2'b00;
	assign irq_clr = (wr_en && paddr == OFS_IRQ_STAT) ? pwdata[1:0] : 2'b00;

	always_ff @(posedge mclk) begin
		if (srst) begin
			irq_stat <= 2'b00;
			irq      <= 1'b0;
		end else begin
			irq_stat <= (irq_stat & ~irq_clr) | irq_set;
			irq      <= |(irq_stat & irq_mask);
		end
	end

	// ----------------------------------------------------------------
	// Trigonometric path
	// ----------------------------------------------------------------
	logic [15:0] angle;
	logic [15:0] trig_bin;
	logic        trig_bad;

	assign angle    = bcd2bin(src);
	assign trig_bad = !bcd_ok(src) || (angle > ANGLE_MAX);
	assign trig_bin = (oper == SEL_COS) ? sine_of(ANGLE_MAX - angle) :
		sine_of(angle);

	// ----------------------------------------------------------------
	// Piecewise-linear interpolation
	// ----------------------------------------------------------------
	logic [15:0]        hdr;
	logic [15:0]        xmax;
	logic [15:0]        x;
	logic [15:0]        prev_x;
	logic [15:0]        prev_y;
	logic [15:0]        xk;
	logic [7:0]         seg;
	logic signed [16:0] dy;
	logic signed [16:0] dx;
	logic signed [16:0] den;
	logic signed [33:0] quot;
	logic signed [33:0] ynew;

	always_comb begin
		dy   = $signed({1'b0, mem_rdata}) - $signed({1'b0, prev_y});
		dx   = $signed({1'b0, x - prev_x});
		den  = $signed({1'b0, xk - prev_x});
		quot = (den == 17'sd0) ? 34'sd0 : (dy * dx) / den;
		ynew = $signed({18'h0, prev_y}) + quot;
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (srst) begin
			state     <= ST_IDLE;
			mem_req   <= '0;
			fin_valid <= 1'b0;
			fin_err   <= 1'b0;
			fin_val   <= RST_WORD;
			hdr       <= RST_WORD;
			xmax      <= RST_WORD;
			x         <= RST_WORD;
			prev_x    <= RST_WORD;
			prev_y    <= RST_WORD;
			xk        <= RST_WORD;
			seg       <= 8'h00;
		end else begin
			fin_valid <= 1'b0;
			if (state == ST_IDLE) begin
				if (go_start && exec_cond) begin
					if (oper_const) begin
						fin_valid <= 1'b1;
						fin_err   <= (oper != SEL_SINE && oper != SEL_COS) || trig_bad;
						fin_val   <= bin2bcd(trig_bin);
					end else begin
						mem_req <= '{rd: 1'b1, addr: oper};
						state   <= ST_HDR;
					end
				end
			end else if (mem_ack) begin
				if (mem_fault) begin
					fin_valid  <= 1'b1;
					fin_err    <= 1'b1;
					mem_req.rd <= 1'b0;
					state      <= ST_IDLE;
				end else begin
					case (state)
						ST_HDR: begin
							hdr          <= mem_rdata;
							x            <= mem_rdata[HDR_IN_BIN] ? src : bcd2bin(src);
							mem_req.addr <= oper + 16'h0001;
							state        <= ST_XMAX;
							if ((!mem_rdata[HDR_IN_BIN] && !bcd_ok(src)) ||
								(int'(mem_rdata[7:0]) >= MAX_SEGMENTS)) begin
								fin_valid  <= 1'b1;
								fin_err    <= 1'b1;
								mem_req.rd <= 1'b0;
								state      <= ST_IDLE;
							end
						end
						ST_XMAX: begin
							xmax         <= mem_rdata;
							mem_req.addr <= oper + 16'h0002;
							state        <= ST_Y0;
							if (x > mem_rdata) begin
								fin_valid  <= 1'b1;
								fin_err    <= 1'b1;
								mem_req.rd <= 1'b0;
								state      <= ST_IDLE;
							end else if (hdr[HDR_MIRROR]) begin
								x <= mem_rdata - x;
							end
						end
						ST_Y0: begin
							prev_y       <= mem_rdata;
							prev_x       <= RST_WORD;
							seg          <= 8'h00;
							mem_req.addr <= oper + 16'h0003;
							state        <= ST_XK;
						end
						ST_XK: begin
							xk           <= mem_rdata;
							mem_req.addr <= mem_req.addr + 16'h0001;
							state        <= ST_YK;
						end
						ST_YK: begin
							if (x <= xk) begin
								fin_valid  <= 1'b1;
								mem_req.rd <= 1'b0;
								state      <= ST_IDLE;
								if (hdr[HDR_OUT_BIN]) begin
									fin_err <= 1'b0;
									fin_val <= ynew[15:0];
								end else begin
									fin_err <= (ynew < 0) || (ynew > FRAC_MAX);
									fin_val <= bin2bcd(ynew[15:0]);
								end
							end else if (seg == hdr[7:0]) begin
								fin_valid  <= 1'b1;
								fin_err    <= 1'b1;
								mem_req.rd <= 1'b0;
								state      <= ST_IDLE;
							end else begin
								prev_x       <= xk;
								prev_y       <= mem_rdata;
								seg          <= seg + 8'h01;
								mem_req.addr <= mem_req.addr + 16'h0001;
								state        <= ST_XK;
							end
						end
						default: begin
							mem_req.rd <= 1'b0;
							state      <= ST_IDLE;
						end
					endcase
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Destination and flags
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (srst) begin
			result <= RST_WORD;
			flags  <= '0;
		end else if (fin_valid) begin
			if (fin_err) begin
				flags.err <= 1'b1;
			end else begin
				result     <= fin_val;
				flags.err  <= 1'b0;
				flags.zero <= (fin_val == RST_WORD);
				flags.top  <= fin_val[15];
			end
		end
	end

endmodule

// file: trig_and_piecewise_linear_evaluator_properties.sv
// Checker for the function evaluation unit, bound to its top module.
// Sees only the unit's ports; sampled on mclk and quiet during srst.
`timescale 1ns/1ps
module trig_and_piecewise_linear_evaluator_properties #(
	parameter int MAX_SEGMENTS = 256
) (
	input wire logic                mclk,
	input wire logic                srst,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [7:0]          paddr,
	input wire logic [31:0]         prdata,
	input wire logic                pready,
	input wire logic                pslverr,
	input wire feval_pkg::mem_req_t mem_req,
	input wire logic                mem_ack,
	input wire feval_pkg::flags_t   flags
);
	import feval_pkg::*;
	logic wr_done;
	assign wr_done = psel && penable && pready && pwrite;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	sequence s_access_start;
		psel && penable && !$past(penable);
	endsequence
	a_one_wait: assert property (s_access_start |-> !pready ##1 pready)
		else $error("pready not in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_slverr_map: assert property (pready |-> pslverr == (paddr[1:0] != 2'b00 || paddr > 8'h1c))
		else $error("pslverr does not match address map");
	a_refused_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read returned data");
	a_req_hold: assert property (mem_req.rd && !mem_ack |=> mem_req.rd && $stable(mem_req.addr))
		else $error("memory request dropped or moved before ack");
	a_req_step: assert property (mem_req.rd && mem_ack |=>
		!mem_req.rd || mem_req.addr == $past(mem_req.addr) + 16'h0001)
		else $error("table not read contiguously");
	a_req_start: assert property ($rose(mem_req.rd) |-> $past(wr_done))
		else $error("table read without a start write");
	a_flags_cause: assert property ($changed(flags) |-> $past(srst) || $past(mem_req.rd) ||
		$past(mem_req.rd, 2) || $past(wr_done, 2) || $past(wr_done, 3))
		else $error("flags changed without an execution");
	a_zero_top: assert property (flags.zero |-> !flags.top)
		else $error("zero and top flags both set");
endmodule
bind trig_and_piecewise_linear_evaluator trig_and_piecewise_linear_evaluator_properties #(
	.MAX_SEGMENTS(MAX_SEGMENTS)
) props_u (
	.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
	.mem_ack(mem_ack), .flags(flags)
);

// file: trig_and_piecewise_linear_evaluator_tb.sv
// Testbench for the function evaluation unit: APB tasks and result checks.
// Assumes the package, the memory model and the checker are compiled first.
`timescale 1ns/1ps
module trig_and_piecewise_linear_evaluator_tb;
	import feval_pkg::*;
	logic        mclk, srst, psel, penable, pwrite, pready, pslverr, irq, mem_ack, mem_fault, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] mem_rdata, fault_addr;
	logic [3:0]  lat;
	mem_req_t    mem_req;
	flags_t      flags;
	int          n_mismatch = 0;
	int          checked = 0;
	int          cyc = 0;
	logic [15:0] tab [6] = '{16'h0014, 16'h0000, 16'h000a, 16'h0064, 16'h0014, 16'h8000};
	logic [15:0] hd [8] = '{16'hc001,16'hc001,16'hc001,16'he001,16'h4001,16'h8001,16'hc001,16'hc001};
	logic [15:0] sr [8] = '{16'h0005,16'h000f,16'h0000,16'h0005,16'h0010,16'h000a,16'h0015,16'h000f};
	logic [15:0] rs [8] = '{16'h0032,16'h4032,16'h0000,16'h4032,16'h0064,16'h0100,16'h0100,16'h0100};
	logic [2:0]  fl [8] = '{3'h0, 3'h0, 3'h2, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1};

	trig_and_piecewise_linear_evaluator dut_u (.mclk(mclk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_rdata(mem_rdata),
		.mem_ack(mem_ack), .mem_fault(mem_fault), .flags(flags), .irq(irq));
	table_mem_model mem_u (.mclk(mclk), .srst(srst), .req(mem_req), .lat(lat),
		.fault_addr(fault_addr), .rdata(mem_rdata), .ack(mem_ack), .fault(mem_fault));

	// ----
	// Tasks
	// ----
	task automatic close_out();
		$display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
		bus(1'b0, a, 16'h0000);
		check(rd[15:0], e);
	endtask
	task automatic run(input logic [15:0] ctl, input logic [15:0] op, input logic [15:0] s);
		bus(1'b1, OFS_CTRL, ctl);
		bus(1'b1, OFS_OPER, op);
		bus(1'b1, OFS_SRC, s);
		bus(1'b1, OFS_GO, 16'h0001);
		do bus(1'b0, OFS_GO, 16'h0000); while (rd[0] !== 1'b0);
	endtask
	task automatic expect_out(input logic [15:0] r, input logic [2:0] f);
		rdchk(OFS_RESULT, r);
		rdchk(OFS_FLAGS, {13'h0000, f});
		check({13'h0000, flags}, {13'h0000, f});
	endtask

	// ----
	// Clock, timeout and sequence
	// ----
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			close_out();
		end
	end
	initial begin
		{srst, psel, penable, pwrite, paddr, pwdata, lat, fault_addr} = {4'h8, 8'h00, 32'h0, 20'h0ffff};
		repeat (12) @(posedge mclk);
		srst <= 1'b0;
		rdchk(OFS_RESULT, RST_WORD);
		rdchk(OFS_FLAGS, RST_WORD);
		bus(1'b0, 8'h22, 16'h0000);
		check({15'h0000, err}, 16'h0001);
		check(rd[15:0], 16'h0000);
		bus(1'b1, OFS_IRQ_MASK, 16'h0003);
		run(16'h0002, SEL_SINE, 16'h0300);
		expect_out(16'h0000, 3'h0);
		rdchk(OFS_IRQ_STAT, 16'h0000);
		run(16'h0003, SEL_SINE, 16'h0000);
		expect_out(16'h0000, 3'h2);
		run(16'h0003, SEL_COS, 16'h0000);
		expect_out(16'h9999, 3'h4);
		run(16'h0003, SEL_SINE, 16'h0900);
		expect_out(16'h9999, 3'h4);
		run(16'h0003, SEL_COS, 16'h0300);
		expect_out(16'h8660, 3'h4);
		run(16'h0003, SEL_SINE, 16'h0300);
		expect_out(16'h5000, 3'h0);
		run(16'h0003, SEL_SINE, 16'h0901);
		expect_out(16'h5000, 3'h1);
		check({15'h0000, irq}, 16'h0001);
		rdchk(OFS_IRQ_STAT, 16'h0003);
		bus(1'b1, OFS_IRQ_STAT, 16'h0003);
		rdchk(OFS_IRQ_STAT, 16'h0000);
		bus(1'b1, OFS_IRQ_MASK, 16'h0000);
		run(16'h0003, 16'h0002, 16'h0300);
		expect_out(16'h5000, 3'h1);
		rdchk(OFS_IRQ_STAT, 16'h0003);
		check({15'h0000, irq}, 16'h0000);
		bus(1'b1, OFS_IRQ_STAT, 16'h0003);
		run(16'h0003, SEL_SINE, 16'h030a);
		expect_out(16'h5000, 3'h1);
		rdchk(OFS_IRQ_STAT, 16'h0003);
		for (int k = 0; k < 6; k++) begin
			mem_u.mem[k + 1] <= tab[k];
		end
		for (int i = 0; i < 8; i++) begin
			mem_u.mem[0] <= hd[i];
			lat <= 4'(i % 3);
			fault_addr <= (i == 7) ? 16'h0104 : 16'hffff;
			bus(1'b1, OFS_IRQ_STAT, 16'h0003);
			run(16'h0001, 16'h0100, sr[i]);
			expect_out(rs[i], fl[i]);
			rdchk(OFS_IRQ_STAT, {14'h0000, fl[i][0], 1'b1});
		end
		close_out();
	end
endmodule
